// ---- rcs_params.svh ----
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH
// Functional notes
// - Pin, clock-unit and core reset outputs are driven independently.
// - Synchronous sources wait for the current bus cycle to end, even when locked.
// - Pending synchronous reset forces the bus monitor on to end stuck cycles.
// - Only byte or word transfers are guaranteed valid under synchronous reset.
// - Asynchronous sources reset the system immediately; a reset instruction, rise wait or pending synchronous reset goes to RCS_IDLE first.
// - External pin low holds core reset; then drive both low 512 more cycles.
// - Other sources drive the pin at least 512 cycles and while asserted.
// - Pin and clock loss synchronous; others asynchronous; instruction drives pin only.
// - After internal reset wait 14 cycles, sample pin, then release vector fetch.
// - During reset bus outputs float or sit at their inactive level.
// - On release drive controls inactive, data read, address driven, start fetch.
// - Reset terminates the bus cycle in progress and readies the reset exception.
// - Reset instruction drives the pin 512 cycles, leaving internal state alone.
// - Cause of the latest reset is kept readable as status.

`define RCS_CLK_PERIOD_PS 5000
`define RCS_STRETCH_CYCLES 512
`define RCS_RISE_CYCLES 14
`define RCS_EXT_MIN_CYCLES 590
`define RCS_CNT_W 10
`define RCS_CAUSE_W 6
`define RCS_CAUSE_EXT 6'h01
`define RCS_CAUSE_POW 6'h02
`define RCS_CAUSE_WDG 6'h04
`define RCS_CAUSE_DBF 6'h08
`define RCS_CAUSE_LOC 6'h10
`define RCS_CAUSE_INS 6'h20
`define RCS_CAUSE_RST 6'h02
`endif

// ---- rcs_pkg.sv ----
`include "rcs_params.svh"
package rcs_pkg;
   typedef enum logic [4:0] {
      RCS_IDLE = 5'h01,
      RCS_WAIT_BUS = 5'h02,
      RCS_HOLD = 5'h04,
      RCS_RISE = 5'h08,
      RCS_INSTR = 5'h10
   } rcs_state_t;
endpackage

// ---- rcs_pin_sync.sv ----
`timescale 1ns/1ps
module rcs_pin_sync (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_pin,
   output logic o_level
);
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic level_q;
   logic level_d;

   always_comb begin
      sync_d = {sync_q[1:0], i_pin};
      level_d = level_q;
      if (sync_q[2] == sync_q[1]) begin
         level_d = sync_q[2];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         sync_q <= 3'h7;
         level_q <= 1'b1;
      end else begin
         sync_q <= sync_d;
         level_q <= level_d;
      end
   end

   assign o_level = level_q;
endmodule

// ---- rcs_reset_control_sequencer.sv ----
`timescale 1ns/1ps
`include "rcs_params.svh"
module rcs_reset_control_sequencer (
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_reset_pin_in,
   input wire logic i_power_up_req,
   input wire logic i_watchdog_req,
   input wire logic i_double_fault_req,
   input wire logic i_clock_loss_req,
   input wire logic i_reset_instr_req,
   input wire logic i_bus_cycle_active,
   input wire logic i_locked_rmw_flag,
   output logic o_reset_pin_out,
   output logic o_reset_pin_oe_n,
   output logic o_pin_reset_drive,
   output logic o_clock_unit_reset,
   output logic o_core_reset,
   output logic o_bus_monitor_force,
   output logic o_bus_terminate,
   output logic o_bus_tristate,
   output logic o_vector_fetch_start,
   output logic [`RCS_CAUSE_W-1:0] o_reset_cause,
   output rcs_pkg::rcs_state_t o_state
);
   import rcs_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchroniser.
   // ----------------------------------------------------------------
   logic pin_level;

   rcs_pin_sync u_pin_sync (
      .i_core_clk(i_core_clk),
      .i_reset(i_reset),
      .i_pin(i_reset_pin_in),
      .o_level(pin_level)
   );

   // ----------------------------------------------------------------
   // Sequencer.
   // ----------------------------------------------------------------
   rcs_state_t state_q;
   rcs_state_t state_d;
   logic [`RCS_CNT_W-1:0] cnt_q;
   logic [`RCS_CNT_W-1:0] cnt_d;
   logic [`RCS_CAUSE_W-1:0] cause_q;
   logic [`RCS_CAUSE_W-1:0] cause_d;
   logic pin_drive_q;
   logic pin_drive_d;
   logic clk_rst_q;
   logic clk_rst_d;
   logic core_rst_q;
   logic core_rst_d;
   logic mon_q;
   logic mon_d;
   logic term_q;
   logic term_d;
   logic tri_q;
   logic tri_d;
   logic fetch_q;
   logic fetch_d;
   logic pin_oe_n_q;
   logic pin_oe_n_d;
   logic ext_low;
   logic async_req;
   logic sync_req;
   logic src_active;

   always_comb begin
      // A low level on the pin that we are not driving ourselves is an outside reset.
      ext_low = !pin_level && !pin_drive_q;
      async_req = i_power_up_req || i_watchdog_req || i_double_fault_req;
      sync_req = ext_low || i_clock_loss_req;
      src_active = async_req || i_clock_loss_req;
      state_d = state_q;
      cnt_d = cnt_q;
      cause_d = cause_q;
      pin_drive_d = pin_drive_q;
      clk_rst_d = clk_rst_q;
      core_rst_d = core_rst_q;
      mon_d = 1'b0;
      term_d = 1'b0;
      tri_d = tri_q;
      fetch_d = 1'b0;
      unique case (state_q)
         RCS_IDLE: begin
            if (async_req) begin
               state_d = RCS_HOLD;
               cnt_d = '0;
               pin_drive_d = 1'b1;
               clk_rst_d = 1'b1;
               core_rst_d = 1'b1;
               tri_d = 1'b1;
               term_d = 1'b1;
               cause_d = i_power_up_req ? `RCS_CAUSE_POW :
                  (i_watchdog_req ? `RCS_CAUSE_WDG : `RCS_CAUSE_DBF);
            end else if (sync_req) begin
               state_d = RCS_WAIT_BUS;
               mon_d = 1'b1;
               cause_d = ext_low ? `RCS_CAUSE_EXT : `RCS_CAUSE_LOC;
            end else if (i_reset_instr_req) begin
               state_d = RCS_INSTR;
               cnt_d = '0;
               pin_drive_d = 1'b1;
               cause_d = `RCS_CAUSE_INS;
            end
         end
         RCS_WAIT_BUS: begin
            mon_d = 1'b1;
            if (async_req) begin
               state_d = RCS_IDLE;
            end else if (!i_bus_cycle_active) begin
               state_d = RCS_HOLD;
               cnt_d = '0;
               mon_d = 1'b0;
               pin_drive_d = !ext_low;
               clk_rst_d = 1'b1;
               core_rst_d = 1'b1;
               tri_d = 1'b1;
               term_d = 1'b1;
            end
         end
         RCS_HOLD: begin
            // An outside pin hold restarts the stretch once the pin is released.
            if (ext_low) begin
               cnt_d = '0;
            end else if (src_active) begin
               cnt_d = '0;
               pin_drive_d = 1'b1;
            end else if (!pin_drive_q) begin
               // The first released cycle takes the pin over so the full stretch is driven.
               pin_drive_d = 1'b1;
            end else if (cnt_q == `RCS_CNT_W'(`RCS_STRETCH_CYCLES - 1)) begin
               state_d = RCS_RISE;
               cnt_d = '0;
               pin_drive_d = 1'b0;
               clk_rst_d = 1'b0;
            end else begin
               cnt_d = cnt_q + 1'b1;
               pin_drive_d = 1'b1;
            end
         end
         RCS_RISE: begin
            if (cnt_q == `RCS_CNT_W'(`RCS_RISE_CYCLES - 1)) begin
               if (ext_low) begin
                  state_d = RCS_HOLD;
                  cnt_d = '0;
                  cause_d = `RCS_CAUSE_EXT;
               end else begin
                  state_d = RCS_IDLE;
                  core_rst_d = 1'b0;
                  tri_d = 1'b0;
                  fetch_d = 1'b1;
               end
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         RCS_INSTR: begin
            // After the pin is let go, the rise time passes before an outside low is believed.
            if (cnt_q == `RCS_CNT_W'(`RCS_STRETCH_CYCLES + `RCS_RISE_CYCLES - 1)) begin
               state_d = RCS_IDLE;
            end else begin
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == `RCS_CNT_W'(`RCS_STRETCH_CYCLES - 1)) begin
                  pin_drive_d = 1'b0;
               end
            end
         end
         default: begin
            state_d = RCS_IDLE;
         end
      endcase
      pin_oe_n_d = !pin_drive_d;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state_q <= RCS_IDLE;
         cnt_q <= '0;
         cause_q <= `RCS_CAUSE_RST;
         pin_drive_q <= 1'b0;
         clk_rst_q <= 1'b0;
         core_rst_q <= 1'b0;
         mon_q <= 1'b0;
         term_q <= 1'b0;
         tri_q <= 1'b0;
         fetch_q <= 1'b0;
         pin_oe_n_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         cause_q <= cause_d;
         pin_drive_q <= pin_drive_d;
         clk_rst_q <= clk_rst_d;
         core_rst_q <= core_rst_d;
         mon_q <= mon_d;
         term_q <= term_d;
         tri_q <= tri_d;
         fetch_q <= fetch_d;
         pin_oe_n_q <= pin_oe_n_d;
      end
   end

   assign o_reset_pin_out = 1'b0;
   assign o_reset_pin_oe_n = pin_oe_n_q;
   assign o_pin_reset_drive = pin_drive_q;
   assign o_clock_unit_reset = clk_rst_q;
   assign o_core_reset = core_rst_q;
   assign o_bus_monitor_force = mon_q;
   assign o_bus_terminate = term_q;
   assign o_bus_tristate = tri_q;
   assign o_vector_fetch_start = fetch_q;
   assign o_reset_cause = cause_q;
   assign o_state = state_q;

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   property p_instr_keeps_core;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_q == RCS_INSTR) |-> !core_rst_q && !clk_rst_q;
   endproperty
   a_instr_keeps_core: assert property (p_instr_keeps_core)
      else $error("Reset instruction disturbed internal resets.");

   property p_instr_len;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_q == RCS_IDLE && state_d == RCS_INSTR) |=> pin_drive_q [*8];
   endproperty
   a_instr_len: assert property (p_instr_len)
      else $error("Reset instruction pin drive too short.");

   property p_async_now;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_q == RCS_IDLE && async_req) |=> core_rst_q && clk_rst_q && pin_drive_q;
   endproperty
   a_async_now: assert property (p_async_now)
      else $error("Asynchronous source did not reset at once.");

   property p_sync_waits;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_q == RCS_WAIT_BUS && i_bus_cycle_active && !async_req) |=> !core_rst_q;
   endproperty
   a_sync_waits: assert property (p_sync_waits)
      else $error("Synchronous reset taken mid cycle.");

   property p_locked_waits;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_q == RCS_WAIT_BUS && i_locked_rmw_flag && i_bus_cycle_active && !async_req)
         |=> (state_q == RCS_WAIT_BUS) && !pin_drive_q;
   endproperty
   a_locked_waits: assert property (p_locked_waits)
      else $error("Synchronous reset taken inside locked sequence.");

   property p_monitor_on;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_q == RCS_WAIT_BUS && state_d == RCS_WAIT_BUS) |=> mon_q;
   endproperty
   a_monitor_on: assert property (p_monitor_on)
      else $error("Bus monitor not forced during pending reset.");

   property p_hold_tri;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_q == RCS_HOLD) |-> tri_q && core_rst_q;
   endproperty
   a_hold_tri: assert property (p_hold_tri)
      else $error("Bus not floated during reset.");

   property p_src_pin;
      @(posedge i_core_clk) disable iff (i_reset)
      (state_q == RCS_HOLD && src_active && !ext_low) |=> pin_drive_q;
   endproperty
   a_src_pin: assert property (p_src_pin)
      else $error("Pin released while source asserted.");

   property p_fetch;
      @(posedge i_core_clk) disable iff (i_reset)
      fetch_q |-> !core_rst_q && !tri_q && $past(state_q == RCS_RISE);
   endproperty
   a_fetch: assert property (p_fetch)
      else $error("Vector fetch without rise wait.");

   c_instr: cover property (@(posedge i_core_clk) state_q == RCS_INSTR);
   c_fetch: cover property (@(posedge i_core_clk) fetch_q);
   c_wait: cover property (@(posedge i_core_clk) state_q == RCS_WAIT_BUS);
endmodule

// ---- rcs_pin_partner.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Outside device sharing the reset line
// ----------------------------------------
module rcs_pin_partner #(parameter int HOLD = 590) (
   input wire logic i_core_clk,
   input wire logic i_start,
   input wire logic i_pin_out,
   input wire logic i_pin_oe_n,
   output logic o_pin,
   output logic o_busy
);
   int cnt = 0;
   assign o_busy = (cnt != 0);
   // The line has a pull-up, so it reads high when nobody pulls it low.
   assign o_pin = !((!i_pin_oe_n && !i_pin_out) || o_busy);
   always @(posedge i_core_clk) begin
      if (i_start) begin
         cnt <= HOLD;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule

// ---- rcs_reset_control_sequencer_tb.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Testbench
// ----------------------------------------
module rcs_reset_control_sequencer_tb;
   import rcs_pkg::*;
   logic clk = 0, rst = 1, pw = 0, wd = 0, df = 0, cl = 0, ins = 0, bus = 0, lck = 0, go = 0;
   logic pin, busy, pin_out, oe_n, drv, cku, core, mon, term, tri_s, fetch;
   logic [5:0] cause;
   rcs_state_t st;
   int bad_count = 0;
   int total_checks = 0;
   rcs_pin_partner partner_u (.i_core_clk(clk), .i_start(go), .i_pin_out(pin_out),
      .i_pin_oe_n(oe_n), .o_pin(pin), .o_busy(busy));
   rcs_reset_control_sequencer dut_u (.i_core_clk(clk), .i_reset(rst), .i_reset_pin_in(pin),
      .i_power_up_req(pw), .i_watchdog_req(wd), .i_double_fault_req(df),
      .i_clock_loss_req(cl), .i_reset_instr_req(ins), .i_bus_cycle_active(bus),
      .i_locked_rmw_flag(lck), .o_reset_pin_out(pin_out), .o_reset_pin_oe_n(oe_n),
      .o_pin_reset_drive(drv), .o_clock_unit_reset(cku), .o_core_reset(core),
      .o_bus_monitor_force(mon), .o_bus_terminate(term), .o_bus_tristate(tri_s),
      .o_vector_fetch_start(fetch), .o_reset_cause(cause), .o_state(st));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task automatic end_of_test;
      $display("Checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [5:0] exp, input logic [5:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic sig(input int k);
      return k == 0 ? drv : k == 1 ? core : k == 2 ? fetch : !busy;
   endfunction
   task automatic wait_for(input int k, input logic v, input int lim, output int n);
      n = 0;
      while (sig(k) !== v) begin
         @(negedge clk);
         n++;
         if (n > lim) begin
            chk("wait bound", 6'h00, 6'h01);
            end_of_test();
         end
      end
   endtask
   // Source already released; measures the stretch and, when core_exp is set, the release to fetch.
   task automatic release_check(input int pre, input logic core_exp);
      int n;
      int m;
      repeat (pre) @(negedge clk);
      chk("pin oe_n", 6'h00, oe_n);
      chk("clock unit", core_exp, cku);
      wait_for(0, 0, 600, n);
      chk("stretch", 6'h01, (n + pre >= 508 && n + pre <= 520));
      chk("clock unit off", 6'h00, cku);
      if (core_exp) begin
         wait_for(2, 1, 30, m);
         chk("rise time", 6'h01, (m >= 12 && m <= 16));
         chk("core off", 6'h00, core);
         chk("tristate off", 6'h00, tri_s);
         @(negedge clk);
         chk("fetch pulse", 6'h00, fetch);
      end
   endtask
   task automatic t_async(input int k);
      @(posedge clk);
      bus <= 1;
      pw <= (k == 0);
      wd <= (k == 1);
      df <= (k == 2);
      repeat (2) @(negedge clk);
      chk("async pin", 6'h01, drv);
      chk("async core", 6'h01, core);
      chk("tristate", 6'h01, tri_s);
      chk("terminate", 6'h01, term);
      @(negedge clk);
      chk("terminate end", 6'h00, term);
      chk("cause", 6'h02 << k, cause);
      repeat (600) @(negedge clk);
      chk("held source", 6'h01, drv);
      @(posedge clk);
      {pw, wd, df, bus} <= 4'h0;
      release_check(5, 1);
   endtask
   task automatic t_sync;
      int n;
      @(posedge clk);
      {bus, lck, cl} <= 3'h7;
      repeat (20) @(negedge clk);
      chk("sync waits", 6'h00, core);
      chk("sync pin waits", 6'h00, drv);
      chk("monitor force", 6'h01, mon);
      chk("sync state", 6'h02, st);
      @(posedge clk);
      {bus, lck} <= 2'h0;
      wait_for(1, 1, 4, n);
      chk("sync pin", 6'h01, drv);
      chk("cause", 6'h10, cause);
      repeat (20) @(negedge clk);
      @(posedge clk);
      cl <= 0;
      release_check(5, 1);
   endtask
   task automatic t_ext;
      int n;
      @(posedge clk);
      go <= 1;
      @(posedge clk);
      go <= 0;
      wait_for(1, 1, 8, n);
      repeat (560) @(negedge clk);
      chk("ext hold", 6'h01, core);
      wait_for(3, 1, 60, n);
      release_check(10, 1);
      chk("cause", 6'h01, cause);
   endtask
   task automatic t_instr;
      int n;
      @(posedge clk);
      ins <= 1;
      @(posedge clk);
      ins <= 0;
      wait_for(0, 1, 3, n);
      chk("instr core", 6'h00, core);
      chk("cause", 6'h20, cause);
      release_check(5, 0);
      chk("instr core after", 6'h00, core);
      repeat (30) @(negedge clk);
      chk("instr no echo", 6'h00, core);
      chk("instr cause kept", 6'h20, cause);
      chk("instr idle", 6'h01, st);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 0;
      @(negedge clk);
      chk("reset pin", 6'h00, drv);
      chk("reset oe_n", 6'h01, oe_n);
      chk("reset state", 6'h01, st);
      chk("reset cause", 6'h02, cause);
      for (int k = 0; k < 3; k++) begin
         t_async(k);
      end
      t_sync();
      t_ext();
      t_instr();
      end_of_test();
   end
endmodule
